//--- core/wdt_pm_top.sv
`include "wdt_pm_defines.svh"

module wdt_pm_top #(
  parameter int WDT_BASE_LOG2 = `WDT_BASE_LOG2
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        ext_fetch,
  input  wire logic        core_ale,
  input  wire logic        core_pstb,
  input  wire logic [7:0]  addr_hi,
  input  wire logic        ext_int_n,
  input  wire logic        irq_pending,
  output logic             irq,
  output logic             wdt_reset,
  output logic             ale,
  output logic             program_store_strobe,
  output logic [7:0]       port0_out,
  output logic [7:0]       port0_oe,
  output logic [7:0]       port1_out,
  output logic [7:0]       port2_out,
  output logic [7:0]       port3_out
);

  wdt_pm_pkg::pm_state_t state;

  logic [2:0]          wdt_period_sel;
  logic [`WDT_W-1:0]   watchdog_counter;
  logic [3:0]          mc_cnt;
  logic                mc_tick;
  logic                idle_request_bit;
  logic                power_down_request_bit;
  logic                wake_en;
  logic                wake_arm;
  logic [3:0]          status;
  logic [3:0]          mask;
  logic [31:0]         port_latch;
  logic [7:0]          aw_addr;
  logic [31:0]         w_data;
  logic [3:0]          w_strb;
  logic [7:0]          ar_addr;
  logic                rd_pend;
  logic [7:0]          ram_q;
  logic                do_wr;
  logic                reg_rst;
  logic                counting;
  logic [3:0]          ev;
  logic [3:0]          rd_clr;
  logic                wr_pcon;
  logic                wr_ram;
  logic                rd_ram;
  logic                wr_known;
  logic                rd_known;

  function automatic logic [`WDT_W-1:0] wdt_limit(input logic [2:0] s);
    logic [4:0] sh;
    sh = 5'(WDT_BASE_LOG2) + {2'h0, (s > `SEL_MAX) ? `SEL_MAX : s};
    return `WDT_W'((21'h1 << sh) - 21'h1);
  endfunction

  // Expires on the tick that would bring the count to the period
  function automatic logic at_limit(input logic [`WDT_W-1:0] c,
                                    input logic [2:0]        s);
    return c + `WDT_W'(1) >= wdt_limit(s);
  endfunction

  function automatic logic is_ram(input logic [7:0] a);
    return a[7:6] == `RAM_BASE_HI;
  endfunction

  function automatic logic is_reg(input logic [7:0] a);
    return a[7:5] == 3'h0 && a[1:0] == 2'h0;
  endfunction

  // Hardware or watchdog reset reinitialises registers except status, never the RAM
  assign reg_rst  = !aresetn || wdt_reset;
  assign do_wr    = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wr_pcon  = do_wr && aw_addr == `ADDR_PCON && w_strb[0];
  assign wr_ram   = do_wr && is_ram(aw_addr) && w_strb[0];
  assign rd_ram   = is_ram(ar_addr);
  assign wr_known = is_reg(aw_addr) || is_ram(aw_addr);
  assign rd_known = is_reg(ar_addr) || is_ram(ar_addr);
  // Oscillator halted in power-down and wake hold
  assign counting = state == wdt_pm_pkg::st_run ||
                    state == wdt_pm_pkg::st_idle;
  assign rd_clr   = (rd_pend && ar_addr == `ADDR_STATUS) ? 4'hF : 4'h0;

  // AXI write address and data, taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      aw_addr       <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_addr       <= s_axi_awaddr;
    end else if (do_wr) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b1;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_data       <= s_axi_wdata;
      w_strb       <= s_axi_wstrb;
    end else if (do_wr) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read: one cycle to fetch, one to form the data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      ar_addr       <= 8'h00;
      rd_pend       <= 1'b0;
    end else begin
      rd_pend <= s_axi_arvalid && s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        ar_addr       <= s_axi_araddr;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (rd_pend) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= rd_known ? `RESP_OKAY : `RESP_SLVERR;
      if (rd_ram) begin
        s_axi_rdata <= {24'h0, ram_q};
      end else begin
        unique case (ar_addr)
          `ADDR_CTRL:   s_axi_rdata <= {29'h0, wdt_period_sel};
          `ADDR_PCON:   s_axi_rdata <= {29'h0, wake_en,
                                        power_down_request_bit,
                                        idle_request_bit};
          `ADDR_STATUS: s_axi_rdata <= {28'h0, status};
          `ADDR_MASK:   s_axi_rdata <= {28'h0, mask};
          `ADDR_COUNT:  s_axi_rdata <= {12'h0, watchdog_counter};
          `ADDR_PORTS:  s_axi_rdata <= port_latch;
          `ADDR_STATE:  s_axi_rdata <= {30'h0, state};
          default:      s_axi_rdata <= 32'h0000_0000;
        endcase
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Select field; upper bits of this register read as zero
  always_ff @(posedge aclk) begin
    if (reg_rst) begin
      wdt_period_sel <= `SEL_RST;
    end else if (do_wr && aw_addr == `ADDR_CTRL && w_strb[0]) begin
      wdt_period_sel <= w_data[2:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (reg_rst) begin
      mask <= `MASK_RST;
    end else if (do_wr && aw_addr == `ADDR_MASK && w_strb[0]) begin
      mask <= w_data[3:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (reg_rst) begin
      port_latch <= {4{`PORT_RST}};
    end else if (do_wr && aw_addr == `ADDR_PORTS) begin
      for (int i = 0; i < 4; i++) begin
        if (w_strb[i]) begin
          port_latch[8*i +: 8] <= w_data[8*i +: 8];
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (reg_rst) begin
      wake_en <= 1'b0;
    end else if (wr_pcon) begin
      wake_en <= w_data[`PC_WEN];
    end
  end

  // Machine-cycle enable; stops with the oscillator
  always_ff @(posedge aclk) begin
    if (reg_rst || !counting) begin
      mc_cnt  <= 4'h0;
      mc_tick <= 1'b0;
    end else begin
      mc_tick <= mc_cnt == `MC_CLKS - 4'h1;
      mc_cnt  <= (mc_cnt == `MC_CLKS - 4'h1) ? 4'h0 : mc_cnt + 4'h1;
    end
  end

  // Watchdog count; a service write restarts it
  always_ff @(posedge aclk) begin
    if (reg_rst) begin
      watchdog_counter <= '0;
    end else if (do_wr && aw_addr == `ADDR_SERVICE) begin
      watchdog_counter <= '0;
    end else if (counting && mc_tick) begin
      if (at_limit(watchdog_counter, wdt_period_sel)) begin
        watchdog_counter <= '0;
      end else begin
        watchdog_counter <= watchdog_counter + `WDT_W'(1);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || wdt_reset) begin
      wdt_reset <= 1'b0;
    end else begin
      // A service landing on the expiry tick still saves the core
      wdt_reset <= counting && mc_tick &&
                   !(do_wr && aw_addr == `ADDR_SERVICE) &&
                   at_limit(watchdog_counter, wdt_period_sel);
    end
  end

  // Power mode sequencer
  always_ff @(posedge aclk) begin
    if (reg_rst) begin
      state                  <= wdt_pm_pkg::st_run;
      idle_request_bit       <= 1'b0;
      power_down_request_bit <= 1'b0;
      wake_arm               <= 1'b0;
    end else begin
      unique case (state)
        wdt_pm_pkg::st_run: begin
          if (wr_pcon) begin
            idle_request_bit       <= w_data[`PC_IDLE];
            power_down_request_bit <= w_data[`PC_PDN];
            // Power-down takes priority when both are requested
            if (w_data[`PC_PDN]) begin
              state    <= wdt_pm_pkg::st_pdown;
              wake_arm <= w_data[`PC_WEN] | wake_en;
            end else if (w_data[`PC_IDLE]) begin
              state <= wdt_pm_pkg::st_idle;
            end
          end
        end
        wdt_pm_pkg::st_idle: begin
          if (irq_pending) begin
            state            <= wdt_pm_pkg::st_run;
            idle_request_bit <= 1'b0;
          end
        end
        wdt_pm_pkg::st_pdown: begin
          if (wake_arm && !ext_int_n) begin
            state <= wdt_pm_pkg::st_wake;
          end
        end
        wdt_pm_pkg::st_wake: begin
          // Line held low while the oscillator settles
          if (ext_int_n) begin
            state                  <= wdt_pm_pkg::st_run;
            idle_request_bit       <= 1'b0;
            power_down_request_bit <= 1'b0;
          end
        end
      endcase
    end
  end

  // Sticky events; a new event beats a read clear
  always_comb begin
    ev = 4'h0;
    ev[`ST_TMO]  = wdt_reset;
    ev[`ST_WAKE] = state == wdt_pm_pkg::st_wake && ext_int_n;
    ev[`ST_PDN]  = state == wdt_pm_pkg::st_run && wr_pcon &&
                   w_data[`PC_PDN];
    ev[`ST_IDLE] = state == wdt_pm_pkg::st_idle && irq_pending;
  end

  // Kept across a watchdog reset so software can see the cause
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status <= 4'h0;
    end else begin
      status <= (status & ~rd_clr) | ev;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((status & ~rd_clr) | ev) & mask);
    end
  end

  // Strobes: core values while running
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ale                  <= 1'b1;
      program_store_strobe <= 1'b1;
    end else begin
      unique case (state)
        wdt_pm_pkg::st_run: begin
          ale                  <= core_ale;
          program_store_strobe <= core_pstb;
        end
        wdt_pm_pkg::st_idle: begin
          ale                  <= 1'b1;
          program_store_strobe <= 1'b1;
        end
        wdt_pm_pkg::st_pdown, wdt_pm_pkg::st_wake: begin
          ale                  <= 1'b0;
          program_store_strobe <= 1'b0;
        end
      endcase
    end
  end

  // Port 0 is open-drain: drives zeros, floats ones
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port0_out <= 8'h00;
      port0_oe  <= 8'h00;
      port1_out <= `PORT_RST;
      port2_out <= `PORT_RST;
      port3_out <= `PORT_RST;
    end else begin
      port0_out <= 8'h00;
      port0_oe  <= (ext_fetch && state != wdt_pm_pkg::st_run) ?
                   8'h00 : ~port_latch[7:0];
      port1_out <= port_latch[15:8];
      port3_out <= port_latch[31:24];
      port2_out <= (ext_fetch && state == wdt_pm_pkg::st_idle) ?
                   addr_hi : port_latch[23:16];
    end
  end

  pm_ram pm_ram_inst (
    .aclk  (aclk),
    .we    (wr_ram),
    .waddr (aw_addr[5:2]),
    .wdata (w_data[7:0]),
    .raddr (s_axi_araddr[5:2]),
    .rdata (ram_q)
  );

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_pdown_freeze;
    state == wdt_pm_pkg::st_pdown |=> $stable(watchdog_counter) ||
      $past(do_wr);
  endproperty
  a_pdown_freeze: assert property (p_pdown_freeze)
    else $error("watchdog moved in power-down");

  property p_wake_hold;
    state == wdt_pm_pkg::st_wake && !ext_int_n && !do_wr |=>
      $stable(watchdog_counter) && state == wdt_pm_pkg::st_wake;
  endproperty
  a_wake_hold: assert property (p_wake_hold)
    else $error("watchdog not held during wake");

  property p_pdown_stay;
    state == wdt_pm_pkg::st_pdown && !wake_arm |=>
      state == wdt_pm_pkg::st_pdown || $past(wdt_reset);
  endproperty
  a_pdown_stay: assert property (p_pdown_stay)
    else $error("left power-down without armed wake");

  property p_both_bits;
    state == wdt_pm_pkg::st_run && wr_pcon && w_data[`PC_PDN] &&
      w_data[`PC_IDLE] |=> state == wdt_pm_pkg::st_pdown;
  endproperty
  a_both_bits: assert property (p_both_bits)
    else $error("power-down not taken");

  property p_wake_exit;
    state == wdt_pm_pkg::st_wake && ext_int_n ##1 !wdt_reset |->
      state == wdt_pm_pkg::st_run && !idle_request_bit &&
      !power_down_request_bit;
  endproperty
  a_wake_exit: assert property (p_wake_exit)
    else $error("bits not cleared on wake");

  property p_strobes;
    (state == wdt_pm_pkg::st_idle |=> ale && program_store_strobe) and
    (state == wdt_pm_pkg::st_pdown |=> !ale && !program_store_strobe);
  endproperty
  a_strobes: assert property (p_strobes)
    else $error("strobe level wrong");

  property p_expire;
    counting && mc_tick && !do_wr &&
      at_limit(watchdog_counter, wdt_period_sel) |=>
      wdt_reset ##1 watchdog_counter == '0 && wdt_period_sel == `SEL_RST;
  endproperty
  a_expire: assert property (p_expire)
    else $error("no reset on expiry");

  property p_idle_count;
    state == wdt_pm_pkg::st_idle && mc_tick && !do_wr &&
      !at_limit(watchdog_counter, wdt_period_sel) |=>
      watchdog_counter == $past(watchdog_counter) + `WDT_W'(1);
  endproperty
  a_idle_count: assert property (p_idle_count)
    else $error("watchdog stopped in idle");

  property p_port0;
    ext_fetch && state == wdt_pm_pkg::st_idle |=> port0_oe == 8'h00;
  endproperty
  a_port0: assert property (p_port0)
    else $error("port 0 driven while fetching");

  property p_sel_reset;
    disable iff (1'b0) !aresetn |=> wdt_period_sel == `SEL_RST;
  endproperty
  a_sel_reset: assert property (p_sel_reset)
    else $error("select not cleared by reset");

endmodule

//--- core/wdt_pm_defines.svh
`ifndef WDT_PM_DEFINES_SVH
`define WDT_PM_DEFINES_SVH

// Register byte addresses
`define ADDR_CTRL     8'h00
`define ADDR_SERVICE  8'h04
`define ADDR_PCON     8'h08
`define ADDR_STATUS   8'h0C
`define ADDR_MASK     8'h10
`define ADDR_COUNT    8'h14
`define ADDR_PORTS    8'h18
`define ADDR_STATE    8'h1C
`define RAM_BASE_HI   2'h1

// Field positions
`define PC_IDLE       0
`define PC_PDN        1
`define PC_WEN        2
`define ST_TMO        0
`define ST_WAKE       1
`define ST_PDN        2
`define ST_IDLE       3

// Reset values and widths
`define SEL_RST       3'h0
`define SEL_MAX       3'h6
`define MASK_RST      4'h0
`define PORT_RST      8'hFF
`define WDT_W         20
`define WDT_BASE_LOG2 14

// One machine cycle spans twelve clocks
`define MC_CLKS       4'hC

`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2

`endif

//--- core/wdt_pm_pkg.sv
package wdt_pm_pkg;

  typedef enum logic [1:0] {
    st_run,
    st_idle,
    st_pdown,
    st_wake
  } pm_state_t;

endpackage

//--- core/pm_ram.sv
module pm_ram (
  input  wire logic       aclk,
  input  wire logic       we,
  input  wire logic [3:0] waddr,
  input  wire logic [7:0] wdata,
  input  wire logic [3:0] raddr,
  output logic      [7:0] rdata
);

  logic [7:0] mem [16];

  // No reset: contents survive every power-down exit
  always_ff @(posedge aclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge aclk) begin
    rdata <= mem[raddr];
  end

endmodule

//--- verif/tb_watchdog_power_mode_control.sv
`include "wdt_pm_defines.svh"

module tb_watchdog_power_mode_control;
  timeunit 1ns;
  timeprecision 1ps;

  // Short base keeps the longest time-out near twelve thousand clocks
  localparam int BASE = 4;
  localparam int CEIL = 40000;

  logic        aclk;
  logic        aresetn;
  logic [7:0]  s_axi_awaddr;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic [7:0]  s_axi_araddr;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  logic        ext_fetch;
  logic        core_ale;
  logic        core_pstb;
  logic [7:0]  addr_hi;
  logic        ext_int_n;
  logic        irq_pending;
  logic        irq;
  logic        wdt_reset;
  logic        ale;
  logic        program_store_strobe;
  logic [7:0]  port0_out;
  logic [7:0]  port0_oe;
  logic [7:0]  port1_out;
  logic [7:0]  port2_out;
  logic [7:0]  port3_out;
  logic [1:0]  last_resp;
  int          bad_count;
  int          num_checks;
  int          cycles;

  wdt_pm_top #(.WDT_BASE_LOG2(BASE)) wdt_pm_top_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .ext_fetch, .core_ale, .core_pstb,
    .addr_hi, .ext_int_n, .irq_pending, .irq, .wdt_reset, .ale,
    .program_store_strobe, .port0_out, .port0_oe, .port1_out,
    .port2_out, .port3_out
  );

  always #20 aclk = ~aclk;

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == CEIL) begin
      bad_count++;
      wrap_up();
    end
  end

  task automatic check(input logic [39:0] got, input logic [39:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // bready and rready stay high so no edge ever drives them twice
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    last_resp = s_axi_bresp;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    last_resp = s_axi_rresp;
  endtask

  task automatic do_reset();
    aresetn <= 1'b0;
    cyc(8);
    aresetn <= 1'b1;
    cyc(1);
  endtask

  task automatic t_reset_vals();
    logic [31:0] d;
    rd(`ADDR_CTRL, d);
    check(d[2:0], 3'h0);
    rd(8'h20, d);
    check({last_resp, d}, {`RESP_SLVERR, 32'h0});
    w(8'h24, 32'h1);
    check(last_resp, `RESP_SLVERR);
    check({ale, program_store_strobe}, 2'h1);
  endtask

  task automatic t_timeout();
    logic [31:0] d;
    int k;
    int p;
    for (int n = 0; n <= 6; n++) begin
      w(`ADDR_CTRL, n);
      w(`ADDR_SERVICE, 32'h0);
      k = 0;
      while (wdt_reset !== 1'b1) begin
        @(posedge aclk);
        k++;
      end
      p = (1 << (BASE + n)) - 1;
      // First tick after the service lands one to twelve clocks later
      check(k > (p - 1) * 12 && k <= p * 12, 1'h1);
      cyc(2);
      rd(`ADDR_CTRL, d);
      check(d[2:0], 3'h0);
    end
  endtask

  task automatic t_irq();
    logic [31:0] d;
    w(`ADDR_CTRL, 32'h6);
    w(`ADDR_SERVICE, 32'h0);
    w(`ADDR_MASK, 32'h0);
    cyc(2);
    check(irq, 1'h0);
    w(`ADDR_MASK, 32'h1);
    cyc(2);
    check(irq, 1'h1);
    rd(`ADDR_STATUS, d);
    check(d[0], 1'h1);
    cyc(2);
    check(irq, 1'h0);
    w(`ADDR_MASK, 32'h0);
  endtask

  task automatic t_idle();
    logic [31:0] d;
    logic [31:0] c;
    w(`ADDR_SERVICE, 32'h0);
    w(`ADDR_PORTS, 32'h963CC35A);
    w(`ADDR_PCON, 32'h1);
    cyc(2);
    rd(`ADDR_STATE, d);
    check(d[1:0], 2'h1);
    check({ale, program_store_strobe}, 2'h3);
    check({port0_out, port0_oe, port1_out, port2_out, port3_out},
          40'h00A5C33C96);
    ext_fetch <= 1'b1;
    cyc(2);
    check({port0_oe, port2_out}, 16'h007E);
    rd(`ADDR_COUNT, c);
    cyc(24);
    rd(`ADDR_COUNT, d);
    check(d > c, 1'h1);
    irq_pending <= 1'b1;
    cyc(2);
    irq_pending <= 1'b0;
    ext_fetch <= 1'b0;
    rd(`ADDR_STATE, d);
    check(d[1:0], 2'h0);
    rd(`ADDR_STATUS, d);
    check(d[3], 1'h1);
  endtask

  task automatic t_pdown_reset();
    logic [31:0] d;
    logic [31:0] c;
    w(`ADDR_SERVICE, 32'h0);
    w(8'h40, 32'hA7);
    w(`ADDR_PCON, 32'h2);
    cyc(2);
    rd(`ADDR_STATE, d);
    check(d[1:0], 2'h2);
    check({ale, program_store_strobe}, 2'h0);
    check({port0_oe, port2_out}, 16'hA53C);
    rd(`ADDR_COUNT, c);
    cyc(24);
    rd(`ADDR_COUNT, d);
    check(d, c);
    // Wake enable was never set, so neither line may end power-down
    ext_int_n <= 1'b0;
    irq_pending <= 1'b1;
    cyc(20);
    rd(`ADDR_STATE, d);
    check(d[1:0], 2'h2);
    ext_int_n <= 1'b1;
    irq_pending <= 1'b0;
    do_reset();
    rd(`ADDR_CTRL, d);
    check(d[2:0], 3'h0);
    w(`ADDR_CTRL, 32'h6);
    w(`ADDR_SERVICE, 32'h0);
    rd(`ADDR_PORTS, d);
    check(d, 32'hFFFFFFFF);
    s_axi_wstrb <= 4'h2;
    w(`ADDR_PORTS, 32'h0);
    s_axi_wstrb <= 4'hF;
    rd(`ADDR_PORTS, d);
    check({d, port1_out}, 40'hFFFF00FF00);
    rd(8'h40, d);
    check(d, 32'hA7);
  endtask

  task automatic t_pdown_wake();
    logic [31:0] d;
    logic [31:0] c;
    w(`ADDR_PORTS, 32'h963CC35A);
    w(8'h44, 32'h3B);
    ext_fetch <= 1'b1;
    w(`ADDR_SERVICE, 32'h0);
    w(`ADDR_PCON, 32'h7);
    cyc(2);
    rd(`ADDR_STATE, d);
    check(d[1:0], 2'h2);
    check({port0_oe, port2_out}, 16'h003C);
    ext_int_n <= 1'b0;
    cyc(3);
    rd(`ADDR_STATE, d);
    check(d[1:0], 2'h3);
    check({ale, program_store_strobe}, 2'h0);
    rd(`ADDR_COUNT, c);
    cyc(60);
    rd(`ADDR_COUNT, d);
    check(d, c);
    ext_int_n <= 1'b1;
    ext_fetch <= 1'b0;
    cyc(3);
    rd(`ADDR_STATE, d);
    check(d[1:0], 2'h0);
    rd(`ADDR_PCON, d);
    check(d[1:0], 2'h0);
    rd(`ADDR_PORTS, d);
    check(d, 32'h963CC35A);
    rd(8'h44, d);
    check(d, 32'h3B);
    rd(`ADDR_STATUS, d);
    check(d[2:1], 2'h3);
    rd(`ADDR_COUNT, c);
    cyc(24);
    rd(`ADDR_COUNT, d);
    check(d > c, 1'h1);
  endtask

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b1;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b1;
    ext_fetch = 1'b0;
    core_ale = 1'b0;
    core_pstb = 1'b1;
    addr_hi = 8'h7E;
    ext_int_n = 1'b1;
    irq_pending = 1'b0;
    bad_count = 0;
    num_checks = 0;
    cycles = 0;
    do_reset();
    t_reset_vals();
    t_timeout();
    t_irq();
    t_idle();
    t_pdown_reset();
    t_pdown_wake();
    wrap_up();
  end
endmodule
